//--- pcc_pkg.sv
// Package for the pulse counter control block: register map, control
// byte layout, mode encoding and state codes.
// Assumes one system clock domain and a plain register port.
package pcc_pkg;

    // Register addresses on the plain register port
    localparam logic [7:0] ADDR_CTRL    = 8'h2f;
    localparam logic [7:0] ADDR_NEW_CNT = 8'h30;
    localparam logic [7:0] ADDR_NEW_PRE = 8'h34;
    localparam logic [7:0] ADDR_MODE    = 8'h38;
    localparam logic [7:0] ADDR_CMD     = 8'h39;
    localparam logic [7:0] ADDR_STATUS  = 8'h3a;
    localparam logic [7:0] ADDR_COUNT   = 8'h3c;
    localparam logic [7:0] ADDR_PRESET  = 8'h40;

    // Command register bit positions (write only, self clearing)
    localparam int CMD_APPLY   = 0;
    localparam int CMD_DEFINE  = 1;
    localparam int CMD_CLR_ERR = 2;

    // Reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
    localparam logic [3:0]  MODE_RESET  = 4'h0;

    // Mode families start at these codes; three variants each
    localparam logic [3:0] MODE_EXT_BASE  = 4'h3;
    localparam logic [3:0] MODE_UPDN_BASE = 4'h6;
    localparam logic [3:0] MODE_QUAD_BASE = 4'h9;
    localparam logic [3:0] MODE_MAX       = 4'hb;

    // Variant within a family
    localparam logic [1:0] VAR_PLAIN = 2'h0;
    localparam logic [1:0] VAR_START = 2'h2;

    typedef enum logic [1:0] {
        FAM_INT  = 2'b00,
        FAM_EXT  = 2'b01,
        FAM_UPDN = 2'b10,
        FAM_QUAD = 2'b11
    } pcc_family_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01
    } pcc_state_e;

    // Control byte, bit 7 down to bit 0
    typedef struct packed {
        logic enable;
        logic upd_cur;
        logic upd_pre;
        logic upd_dir;
        logic dir_up;
        logic rate_1x;
        logic start_low;
        logic reset_low;
    } pcc_ctrl_s;

    // Snapshot taken by one apply command
    typedef struct packed {
        pcc_ctrl_s   ctrl;
        logic [31:0] cur;
        logic [31:0] pre;
    } pcc_apply_s;

    // Status word, bit 7 down to bit 0
    typedef struct packed {
        logic loading;
        logic def_error;
        logic defined;
        logic enabled;
        logic greater;
        logic equal;
        logic dir_up;
        logic mode_ok;
    } pcc_status_s;

endpackage

//--- pcc_counter.sv
// Pulse counter control: mode decode, apply command, count logic and
// the three counter events for one high-speed pulse counter.
// Assumes count, direction, reset and start inputs are already
// synchronous to core_clk and filtered elsewhere.

`timescale 1ns/1ps

module pcc_counter
    import pcc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Controller run state
    input  wire logic        run_mode,
    // Count inputs
    input  wire logic        cnt_in_a,
    input  wire logic        cnt_in_b,
    input  wire logic        ext_reset_in,
    input  wire logic        ext_start_in,
    // Counter state and events
    output logic      [31:0] count_value,
    output logic             count_up,
    output logic             count_enabled,
    output logic             evt_equal,
    output logic             evt_dir_change,
    output logic             evt_ext_reset,
    output logic             mode_error
);

    // Mode family from mode code
    function automatic pcc_family_e mode_family(input logic [3:0] m);
        pcc_family_e f;
        if (m >= MODE_QUAD_BASE) begin
            f = FAM_QUAD;
        end else if (m >= MODE_UPDN_BASE) begin
            f = FAM_UPDN;
        end else if (m >= MODE_EXT_BASE) begin
            f = FAM_EXT;
        end else begin
            f = FAM_INT;
        end
        return f;
    endfunction

    // Variant within family: plain, reset, reset and start
    function automatic logic [1:0] mode_variant(input logic [3:0] m);
        logic [3:0] d;
        if (m >= MODE_QUAD_BASE) begin
            d = m - MODE_QUAD_BASE;
        end else if (m >= MODE_UPDN_BASE) begin
            d = m - MODE_UPDN_BASE;
        end else if (m >= MODE_EXT_BASE) begin
            d = m - MODE_EXT_BASE;
        end else begin
            d = m;
        end
        return d[1:0];
    endfunction

    // Software-visible storage
    pcc_ctrl_s   ctrl_byte;
    logic [31:0] new_count_holding;
    logic [31:0] new_preset_holding;
    logic [3:0]  mode_req;
    logic [3:0]  mode_active;
    logic        mode_defined;
    logic        def_error;

    // Live counter state
    pcc_state_e  state;
    pcc_apply_s  snap;
    pcc_ctrl_s   cfg;
    logic [31:0] preset;
    logic        a_q;
    logic        b_q;
    logic        rst_q;
    logic        run_q;

    // Register port decode
    wire         wr_ctrl   = reg_write & (reg_addr == ADDR_CTRL);
    wire         wr_cnt    = reg_write & (reg_addr == ADDR_NEW_CNT);
    wire         wr_pre    = reg_write & (reg_addr == ADDR_NEW_PRE);
    wire         wr_mode   = reg_write & (reg_addr == ADDR_MODE);
    wire         wr_cmd    = reg_write & (reg_addr == ADDR_CMD);
    wire         apply_cmd = wr_cmd & reg_wdata[CMD_APPLY];
    wire         define_cmd = wr_cmd & reg_wdata[CMD_DEFINE];
    wire         clr_err   = wr_cmd & reg_wdata[CMD_CLR_ERR];

    // Mode decode of the defined mode
    wire pcc_family_e family  = mode_family(mode_active);
    wire logic [1:0]  variant = mode_variant(mode_active);
    wire         has_reset = mode_defined & (variant != VAR_PLAIN);
    wire         has_start = mode_defined & (variant == VAR_START);

    // Polarity: bit set means the input is active low
    wire         reset_act = ext_reset_in ^ cfg.reset_low;
    wire         start_act = ext_start_in ^ cfg.start_low;
    wire         rst_rise  = reset_act & ~rst_q;

    // Input edges; inputs are taken as synchronous
    wire         a_rise = cnt_in_a & ~a_q;
    wire         a_edge = cnt_in_a ^ a_q;
    wire         b_rise = cnt_in_b & ~b_q;
    wire         b_edge = cnt_in_b ^ b_q;

    // Counting allowed: enabled, idle, started, not held in reset
    wire         live   = count_enabled & mode_defined &
                          (state == ST_IDLE);
    wire         gated  = live & (~has_start | start_act) &
                          ~(has_reset & reset_act);

    // Quadrature: A leading B counts up, both edges at once ignored at 4x rate
    wire         quad_up4 = a_edge ? (cnt_in_a != cnt_in_b)
                                   : (cnt_in_a == cnt_in_b);
    wire         quad_st4 = a_edge ^ b_edge;
    wire         quad_st  = cfg.rate_1x ? a_rise : quad_st4;
    wire         quad_up  = cfg.rate_1x ? ~cnt_in_b : quad_up4;

    // Step and direction per family
    logic        step_raw;
    logic        step_up;
    always_comb begin
        step_raw = 1'b0;
        step_up  = count_up;
        case (family)
            FAM_INT: begin
                step_raw = a_rise;
                step_up  = count_up;
            end
            FAM_EXT: begin
                step_raw = a_rise;
                step_up  = cnt_in_b;
            end
            FAM_UPDN: begin
                step_raw = a_rise ^ b_rise;
                step_up  = a_rise;
            end
            FAM_QUAD: begin
                step_raw = quad_st;
                step_up  = quad_up;
            end
            default: begin
                step_raw = 1'b0;
                step_up  = count_up;
            end
        endcase
    end

    wire         step     = gated & step_raw;
    wire  [31:0] step_val = step_up ? count_value + 32'h0000_0001
                                    : count_value - 32'h0000_0001;

    // Reset activation counts only while the counter is live
    wire         rst_hit  = live & has_reset & rst_rise;
    wire         rst_hold = live & has_reset & reset_act;

    // Events computed from the step just taken, not the stored values
    wire         next_evt_equal = step & (step_val == preset);
    wire         next_evt_dir   = step & (family != FAM_INT) &
                                  (step_up != count_up);
    wire         next_evt_rst   = rst_hit;

    // Next count: load wins over external reset, reset over counting
    logic [31:0] next_count;
    always_comb begin
        if (state == ST_LOAD && snap.ctrl.upd_cur) begin
            next_count = snap.cur;
        end else if (rst_hold) begin
            next_count = WORD_RESET;
        end else if (step) begin
            next_count = step_val;
        end else begin
            next_count = count_value;
        end
    end

    // Direction: applied value, otherwise the observed count direction
    logic        next_up;
    always_comb begin
        if (state == ST_LOAD && snap.ctrl.upd_dir) begin
            next_up = snap.ctrl.dir_up;
        end else if (step && family != FAM_INT) begin
            next_up = step_up;
        end else begin
            next_up = count_up;
        end
    end

    // Mode define: once per run entry and only for a known code
    wire         run_enter  = run_mode & ~run_q;
    wire         def_ok     = define_cmd & ~mode_defined &
                              (mode_req <= MODE_MAX);
    wire         def_bad    = define_cmd & ~def_ok;
    wire         next_defd  = def_ok | (mode_defined & ~run_enter);
    // Error set wins over a clear in the same cycle
    wire         next_err   = def_bad | (def_error & ~clr_err);

    // Status word and read selection
    pcc_status_s status;
    assign status = '{
        loading:   (state == ST_LOAD),
        def_error: def_error,
        defined:   mode_defined,
        enabled:   count_enabled,
        greater:   ($signed(count_value) > $signed(preset)),
        equal:     (count_value == preset),
        dir_up:    count_up,
        mode_ok:   (mode_active <= MODE_MAX)
    };

    logic [31:0] rd_sel;
    always_comb begin
        case (reg_addr)
            ADDR_CTRL:    rd_sel = {24'h00_0000, ctrl_byte};
            ADDR_NEW_CNT: rd_sel = new_count_holding;
            ADDR_NEW_PRE: rd_sel = new_preset_holding;
            ADDR_MODE:    rd_sel = {20'h0_0000, mode_req, 4'h0,
                                    mode_active};
            ADDR_STATUS:  rd_sel = {24'h00_0000, status};
            ADDR_COUNT:   rd_sel = count_value;
            ADDR_PRESET:  rd_sel = preset;
            default:      rd_sel = WORD_RESET;
        endcase
    end

    // Software registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_byte          <= CTRL_RESET;
            new_count_holding  <= WORD_RESET;
            new_preset_holding <= WORD_RESET;
            mode_req           <= MODE_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_byte <= reg_wdata[7:0];
            end
            if (wr_cnt) begin
                new_count_holding <= reg_wdata;
            end
            if (wr_pre) begin
                new_preset_holding <= reg_wdata;
            end
            if (wr_mode) begin
                mode_req <= reg_wdata[3:0];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= WORD_RESET;
        end else begin
            reg_rdata <= reg_read ? rd_sel : WORD_RESET;
        end
    end

    // Mode definition state; a bad define leaves the mode untouched
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_active  <= MODE_RESET;
            mode_defined <= 1'b0;
            def_error    <= 1'b0;
            run_q        <= 1'b0;
        end else begin
            if (def_ok) begin
                mode_active <= mode_req;
            end
            mode_defined <= next_defd;
            def_error    <= next_err;
            run_q        <= run_mode;
        end
    end

    // Apply sequencer: snapshot in the strobe cycle, update one later.
    // A second apply during the load simply takes a fresh snapshot.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            snap  <= '0;
        end else begin
            if (apply_cmd) begin
                snap  <= '{ctrl: ctrl_byte,
                           cur: new_count_holding,
                           pre: new_preset_holding};
                state <= ST_LOAD;
            end else begin
                state <= ST_IDLE;
            end
        end
    end

    // Applied configuration: enable, polarity, rate and preset together
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg           <= CTRL_RESET;
            count_enabled <= 1'b0;
            preset        <= WORD_RESET;
        end else if (state == ST_LOAD) begin
            cfg           <= snap.ctrl;
            count_enabled <= snap.ctrl.enable;
            if (snap.ctrl.upd_pre) begin
                preset <= snap.pre;
            end
        end
    end

    // Count, direction and input history
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_value <= WORD_RESET;
            count_up    <= 1'b0;
            a_q         <= 1'b0;
            b_q         <= 1'b0;
            rst_q       <= 1'b0;
        end else begin
            count_value <= next_count;
            count_up    <= next_up;
            a_q         <= cnt_in_a;
            b_q         <= cnt_in_b;
            rst_q       <= reset_act;
        end
    end

    // Event pulses, one cycle each, silent while loading; mode_error follows the define error flag
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            evt_equal      <= 1'b0;
            evt_dir_change <= 1'b0;
            evt_ext_reset  <= 1'b0;
            mode_error     <= 1'b0;
        end else begin
            evt_equal      <= next_evt_equal;
            evt_dir_change <= next_evt_dir;
            evt_ext_reset  <= next_evt_rst;
            mode_error     <= next_err;
        end
    end

endmodule

//--- pcc_counter_monitor.sv
// Port checker for the pulse counter control block.
// Assumes it is bound onto pcc_counter; one clock, async reset.
`timescale 1ns/1ps
module pcc_counter_monitor
    import pcc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic [31:0] count_value,
    input wire logic        count_up,
    input wire logic        count_enabled,
    input wire logic        evt_equal,
    input wire logic        evt_dir_change,
    input wire logic        evt_ext_reset,
    input wire logic        mode_error
);
    logic [7:0]  ctrl_q;
    logic [31:0] cur_q;
    // Command decode; a load lands two edges after the strobe
    wire cmd_wr    = reg_write && (reg_addr == ADDR_CMD);
    wire cmd_apply = cmd_wr && reg_wdata[CMD_APPLY];
    wire cmd_def   = cmd_wr && reg_wdata[CMD_DEFINE];
    wire wr_ctrl   = reg_write && (reg_addr == ADDR_CTRL);
    wire wr_cur    = reg_write && (reg_addr == ADDR_NEW_CNT);
    wire any_evt   = evt_equal || evt_dir_change || evt_ext_reset;

    // Shadows of what software last wrote, to judge an apply
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
            cur_q  <= WORD_RESET;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[7:0];
            if (wr_cur) cur_q <= reg_wdata;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_apply_take: assert property (cmd_apply |-> ##2
        (count_enabled == $past(ctrl_q[7], 2)) &&
        (!$past(ctrl_q[6], 2) || count_value == $past(cur_q, 2)))
        else $error("apply result differs from snapshot");
    a_load_quiet: assert property (cmd_apply |-> ##2 !any_evt)
        else $error("event during load cycle");
    a_count_gated: assert property (
        $changed(count_value) && !$past(count_enabled)
        |-> $past(cmd_apply, 2) || count_value == 32'h0)
        else $error("count moved while disabled");
    a_step_one: assert property (
        $changed(count_value) && !$past(cmd_apply, 2) &&
        count_value != 32'h0 |->
        (count_value - $past(count_value)) inside
        {32'h1, 32'hffff_ffff})
        else $error("count step not one");
    a_evt_enabled: assert property (any_evt |-> $past(count_enabled))
        else $error("event while disabled");
    a_equal_step: assert property (evt_equal |-> $changed(count_value))
        else $error("equal event without a step");
    a_dir_event: assert property (evt_dir_change |-> $changed(count_up))
        else $error("direction event without change");
    a_reset_zero: assert property (evt_ext_reset |-> count_value == 0)
        else $error("external reset left count nonzero");
    a_error_cause: assert property ($rose(mode_error) |-> $past(cmd_def))
        else $error("define error without define");
endmodule

bind pcc_counter pcc_counter_monitor i_mon (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_write     (reg_write),
    .count_value   (count_value),
    .count_up      (count_up),
    .count_enabled (count_enabled),
    .evt_equal     (evt_equal),
    .evt_dir_change(evt_dir_change),
    .evt_ext_reset (evt_ext_reset),
    .mode_error    (mode_error)
);

//--- pcc_source.sv
// Far-side model of the count, direction, reset and start inputs.
// Assumes the bench calls its tasks; lines change after rising edges.
`timescale 1ns/1ps
module pcc_source (
    input wire logic core_clk,
    output logic     cnt_in_a,
    output logic     cnt_in_b,
    output logic     ext_reset_in,
    output logic     ext_start_in
);
    // All lines idle low until the bench sets other idle levels
    initial begin
        cnt_in_a = 1'b0;
        cnt_in_b = 1'b0;
        ext_reset_in = 1'b0;
        ext_start_in = 1'b0;
    end
    // One rise on A or B; trailing edges let the count settle
    task automatic pulse(input logic on_b);
        @(posedge core_clk);
        if (on_b) cnt_in_b <= 1'b1;
        else cnt_in_a <= 1'b1;
        @(posedge core_clk);
        cnt_in_a <= 1'b0;
        if (on_b) cnt_in_b <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // Direction level for external direction modes
    task automatic level(input logic up);
        @(posedge core_clk);
        cnt_in_b <= up;
    endtask
    // One full quadrature cycle, A leading B
    task automatic quad();
        @(posedge core_clk);
        cnt_in_a <= 1'b1;
        @(posedge core_clk);
        cnt_in_b <= 1'b1;
        @(posedge core_clk);
        cnt_in_a <= 1'b0;
        @(posedge core_clk);
        cnt_in_b <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // Reset pulse away from the idle level, so either polarity works
    task automatic kick();
        @(posedge core_clk);
        ext_reset_in <= ~ext_reset_in;
        @(posedge core_clk);
        ext_reset_in <= ~ext_reset_in;
        repeat (3) @(posedge core_clk);
    endtask
    // Idle levels of the reset and start lines
    task automatic lines(input logic rst, input logic st);
        @(posedge core_clk);
        ext_reset_in <= rst;
        ext_start_in <= st;
    endtask
endmodule

//--- test_high_speed_counter_control.sv
// Testbench for the pulse counter control block.
// Assumes the bound checker and the pcc_source model.
`timescale 1ns/1ps
module test_high_speed_counter_control;
    import pcc_pkg::*;
    logic core_clk, reset_n, reg_write, reg_read, run_mode;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, count_value, d;
    logic cnt_in_a, cnt_in_b, ext_reset_in, ext_start_in;
    logic count_up, count_enabled, evt_equal, evt_dir_change;
    logic evt_ext_reset, mode_error;
    int   bad_count = 0;
    int   compares = 0;
    int   eq_n = 0;
    int   dir_n = 0;
    int   rst_n_seen = 0;

    pcc_counter i_dut (
        .core_clk      (core_clk),
        .reset_n       (reset_n),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_write     (reg_write),
        .reg_read      (reg_read),
        .reg_rdata     (reg_rdata),
        .run_mode      (run_mode),
        .cnt_in_a      (cnt_in_a),
        .cnt_in_b      (cnt_in_b),
        .ext_reset_in  (ext_reset_in),
        .ext_start_in  (ext_start_in),
        .count_value   (count_value),
        .count_up      (count_up),
        .count_enabled (count_enabled),
        .evt_equal     (evt_equal),
        .evt_dir_change(evt_dir_change),
        .evt_ext_reset (evt_ext_reset),
        .mode_error    (mode_error)
    );
    pcc_source i_src (
        .core_clk    (core_clk),
        .cnt_in_a    (cnt_in_a),
        .cnt_in_b    (cnt_in_b),
        .ext_reset_in(ext_reset_in),
        .ext_start_in(ext_start_in)
    );

    // 10 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Tally event pulses; each stands one cycle
    always @(posedge core_clk) begin
        if (evt_equal === 1'b1) eq_n++;
        if (evt_dir_change === 1'b1) dir_n++;
        if (evt_ext_reset === 1'b1) rst_n_seen++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask
    task automatic prog(input logic [7:0] c, input logic [31:0] cur, pre);
        wr(ADDR_CTRL, {24'h0, c});
        wr(ADDR_NEW_CNT, cur);
        wr(ADDR_NEW_PRE, pre);
        wr(ADDR_CMD, 32'h1);
        repeat (3) @(posedge core_clk);
    endtask
    // Re-entering run frees the mode for one define
    task automatic enter(input logic [31:0] m);
        @(posedge core_clk);
        run_mode <= 1'b0;
        @(posedge core_clk);
        run_mode <= 1'b1;
        wr(ADDR_MODE, m);
        wr(ADDR_CMD, 32'h2);
    endtask
    task automatic t_regs();
        rd(ADDR_CTRL, d); chk(d, 32'h0);
        rd(ADDR_NEW_CNT, d); chk(d, 32'h0);
        wr(ADDR_NEW_PRE, 32'h8765_4321);
        rd(ADDR_NEW_PRE, d); chk(d, 32'h8765_4321);
        rd(8'h50, d); chk(d, 32'h0);
        wr(ADDR_COUNT, 32'h55);
        rd(ADDR_COUNT, d); chk(d, 32'h0);
        $display("t_regs done");
    endtask
    task automatic t_mode0();
        enter(32'h0);
        prog(8'hf8, 32'h0, 32'h3);
        chk(count_value, 32'h0);
        chk({31'h0, count_enabled & count_up}, 32'h1);
        repeat (3) i_src.pulse(1'b0);
        chk(count_value, 32'h3);
        prog(8'h90, 32'h0, 32'h0);
        i_src.pulse(1'b0);
        chk({count_value[30:0], count_up}, 32'h4);
        prog(8'h98, 32'h0, 32'h0);
        i_src.pulse(1'b0);
        chk({count_value[30:0], count_up}, 32'h7);
        chk(32'(eq_n), 32'h2);
        prog(8'hc0, 32'h5, 32'h63);
        rd(ADDR_PRESET, d);
        chk(d ^ count_value, 32'h6);
        prog(8'ha0, 32'h0, 32'h9);
        rd(ADDR_PRESET, d);
        chk({d[15:0], count_value[15:0]}, 32'h0009_0005);
        prog(8'h00, 32'h0, 32'h0);
        repeat (2) i_src.pulse(1'b0);
        chk({count_value[30:0], count_enabled}, 32'ha);
        wr(ADDR_MODE, 32'h5);
        wr(ADDR_CMD, 32'h2);
        rd(ADDR_MODE, d);
        chk({d[30:0], mode_error}, 32'ha01);
        chk(32'(dir_n), 32'h0);
        $display("t_mode0 done");
    endtask
    task automatic t_mode4();
        enter(32'h4);
        prog(8'hf8, 32'h7, 32'h64);
        i_src.level(1'b1);
        i_src.pulse(1'b0);
        chk(count_value, 32'h8);
        i_src.level(1'b0);
        i_src.pulse(1'b0);
        chk({count_value[30:0], count_up}, 32'he);
        chk(32'(dir_n), 32'h1);
        i_src.kick();
        chk(count_value, 32'h0);
        chk(32'(rst_n_seen), 32'h1);
        $display("t_mode4 done");
    endtask
    task automatic t_mode69();
        enter(32'h6);
        prog(8'hf8, 32'h0, 32'h32);
        i_src.pulse(1'b0);
        i_src.pulse(1'b0);
        i_src.pulse(1'b1);
        chk(count_value, 32'h1);
        enter(32'h9);
        prog(8'hf8, 32'h0, 32'h32);
        i_src.quad();
        chk(count_value, 32'h4);
        prog(8'hfc, 32'h0, 32'h32);
        i_src.quad();
        chk(count_value, 32'h1);
        $display("t_mode69 done");
    endtask
    // Reset and start both active low; idle levels set while in mode 9
    task automatic t_mode5();
        i_src.lines(1'b1, 1'b1);
        enter(32'h5);
        wr(ADDR_CMD, 32'h4);
        prog(8'hfb, 32'h0, 32'h2);
        i_src.level(1'b1);
        i_src.pulse(1'b0);
        chk(count_value, 32'h0);
        i_src.lines(1'b1, 1'b0);
        repeat (2) i_src.pulse(1'b0);
        chk(count_value, 32'h2);
        chk(32'(eq_n), 32'h3);
        i_src.kick();
        chk(count_value, 32'h0);
        chk(32'(rst_n_seen), 32'h2);
        rd(ADDR_STATUS, d);
        chk({d[30:0], mode_error}, 32'h66);
        $display("t_mode5 done");
    endtask
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Hang guard; far above the whole run
    initial begin
        #5000000;
        bad_count++;
        end_sim();
    end
    // Reset for two cycles, then the scenarios
    initial begin
        reset_n = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        run_mode = 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        t_regs();
        t_mode0();
        t_mode4();
        t_mode69();
        t_mode5();
        end_sim();
    end
endmodule
